/* File: shared/adcct_pkg.sv */
// Purpose: Constants, types and register map of the converter timing block
// Assumes: pclk is the master clock; 32-bit APB register access
// Notes:   Counts are in basic clock or system clock periods

package adcct_pkg;

    // ----------------------------------------------------------------
    // Bus and register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_STATUS  = 12'h004;
    localparam logic [11:0] OFS_RESULT  = 12'h008;
    localparam logic [11:0] OFS_SYSCTL  = 12'h00C;
    localparam logic [11:0] OFS_INCLK   = 12'h010;

    // Reset values
    localparam logic [15:0] CTRL_RST    = 16'h0004;
    localparam logic        SYSCTL_RST  = 1'h0;
    localparam logic [7:0]  INCLK_RST   = 8'h03;

    // Status field positions
    localparam int          ST_BUSY_BIT = 0;
    localparam int          ST_DONE_BIT = 1;
    localparam int          ST_CAL_BIT  = 2;

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    localparam logic [7:0]  DIV_SEL0    = 8'h04;
    localparam logic [7:0]  DIV_SEL1    = 8'h02;
    localparam logic [7:0]  DIV_SEL2    = 8'h10;
    localparam logic [7:0]  DIV_SEL3    = 8'h08;
    localparam logic [6:0]  SMP_SEL0    = 7'h08;
    localparam logic [6:0]  SMP_SEL1    = 7'h10;
    localparam logic [6:0]  SMP_SEL2    = 7'h20;
    localparam logic [6:0]  SMP_SEL3    = 7'h40;
    localparam logic [6:0]  CONV10_PC   = 7'h34;
    localparam logic [6:0]  CONV10_NPC  = 7'h28;
    localparam logic [6:0]  CONV8_PC    = 7'h2C;
    localparam logic [6:0]  CONV8_NPC   = 7'h20;
    localparam logic [6:0]  POSTCAL_BC  = 7'h0C;
    localparam logic [6:0]  LOAD_SYS    = 7'h06;
    localparam logic [13:0] CAL_MIN_BC  = 14'h01E4;
    localparam logic [13:0] CAL_MAX_BC  = 14'h2DB0;
    localparam logic [9:0]  CODE_ZERO   = 10'h000;
    localparam logic [9:0]  CODE_FULL   = 10'h3FF;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONV,
        ST_LOAD
    } adcct_state_t;

    typedef struct packed {
        logic [1:0] conv_clock_divider_select;
        logic [1:0] sample_time_select;
        logic       improved_clk;
        logic [7:0] rsv;
        logic       post_cal_en;
        logic       res8;
        logic       start;
    } adcct_ctrl_t;

    typedef struct packed {
        logic       below;
        logic       above;
        logic [9:0] code;
    } adcct_sample_t;

endpackage

/* File: logic/adcct_tick_div.sv */
// Purpose: Enable-pulse divider producing one tick every div input steps
// Assumes: div of zero behaves as one
// Notes:   clr restarts the period so a phase begins on a whole period

`timescale 1ns/10ps
`default_nettype none

module adcct_tick_div #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clk_en,
    // Control
    input  wire logic         step,
    input  wire logic         clr,
    input  wire logic [W-1:0] div,
    // Result
    output wire logic         tick
);

    logic [W-1:0] cnt_q;
    wire  logic [W-1:0] last_w;
    wire  logic         wrap_w;

    // Terminal count, guarding a zero divisor
    assign last_w = (div == '0) ? '0 : div - W'(1);
    assign wrap_w = (cnt_q >= last_w);
    assign tick   = step & wrap_w & ~clr;

    // Step counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (clr || (step && wrap_w)) begin
                cnt_q <= '0;
            end else if (step) begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end

endmodule

`default_nettype wire

/* File: logic/adcct_timing.sv */
// Purpose: Converter timing control with APB registers and clock strobes
// Assumes: Analog values arrive as pins from outside the pclk domain
// Notes:   All state freezes while clk_en is low

`timescale 1ns/10ps
`default_nettype none

module adcct_timing
    import adcct_pkg::*;
(
    // Clock, enable, reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Analog front end pins
    input  wire logic [9:0]        ain_code,
    input  wire logic              ain_below,
    input  wire logic              ain_above,
    input  wire logic              ref_noisy,
    // Clock strobes and status
    output logic                   cpu_clk_en,
    output logic                   sys_clk_en,
    output logic                   sample_en,
    output logic                   cal_busy
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    adcct_sample_t pin_m_q;
    adcct_sample_t pin_s_q;
    logic          noisy_m_q;
    logic          noisy_s_q;

    // Two stages; only the second stage feeds logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_m_q   <= '0;
            pin_s_q   <= '0;
            noisy_m_q <= 1'b0;
            noisy_s_q <= 1'b0;
        end else if (clk_en) begin
            pin_m_q   <= '{below: ain_below, above: ain_above, code: ain_code};
            pin_s_q   <= pin_m_q;
            noisy_m_q <= ref_noisy;
            noisy_s_q <= noisy_m_q;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0]   ctrl_q;
    logic          halve_q;
    logic [7:0]    inclk_q;
    logic [9:0]    result_q;
    logic          done_q;
    logic          cal_q;
    logic [13:0]   cal_cnt_q;
    adcct_state_t  state_q;
    adcct_state_t  state_d;
    logic [6:0]    cnt_q;
    adcct_sample_t held_q;
    logic          pready_q;
    logic          pslverr_q;
    logic [31:0]   prdata_q;
    logic          cpu_en_q;
    logic          sys_en_q;
    logic          sample_q;

    wire adcct_ctrl_t ctl = adcct_ctrl_t'(ctrl_q);

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire logic acc_w    = psel & penable;
    wire logic fire_w   = acc_w & pready_q;
    wire logic wr_w     = fire_w & pwrite;
    wire logic hit_ctl  = (paddr == OFS_CTRL);
    wire logic hit_st   = (paddr == OFS_STATUS);
    wire logic hit_res  = (paddr == OFS_RESULT);
    wire logic hit_sys  = (paddr == OFS_SYSCTL);
    wire logic hit_clk  = (paddr == OFS_INCLK);
    wire logic hit_w    = hit_ctl | hit_st | hit_res | hit_sys | hit_clk;
    wire logic busy_w   = (state_q != ST_IDLE);
    wire logic start_w  = wr_w & hit_ctl & pwdata[0] & ~busy_w;
    wire logic done_clr = wr_w & hit_st & pwdata[ST_DONE_BIT];

    // Read mux; start bit reads as zero
    wire logic [31:0] rd_w =
        hit_ctl ? {16'h0000, ctrl_q[15:1], 1'b0} :
        hit_st  ? {29'h0, cal_q, done_q, busy_w} :
        hit_res ? {22'h0, result_q} :
        hit_sys ? {31'h0, halve_q} :
        hit_clk ? {24'h0, inclk_q} : 32'h0000_0000;

    // One wait state so every answer comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_q  <= acc_w & ~pready_q;
            pslverr_q <= acc_w & ~pready_q & ~hit_w;
            prdata_q  <= (acc_w & ~pready_q & ~pwrite) ? rd_w : 32'h0000_0000;
        end
    end

    // Software registers, written at the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= CTRL_RST;
            halve_q <= SYSCTL_RST;
            inclk_q <= INCLK_RST;
        end else if (clk_en && wr_w) begin
            if (hit_ctl) ctrl_q  <= {pwdata[15:1], 1'b0};
            if (hit_sys) halve_q <= pwdata[0];
            if (hit_clk) inclk_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Clock strobes
    // ----------------------------------------------------------------
    wire logic       sys_tick;
    wire logic       bc_tick;
    wire logic [7:0] sys_div_w = halve_q ? 8'h02 : 8'h01;

    // System strobe equals the CPU strobe rate
    adcct_tick_div #(.W(8)) u_sys_div (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .step    (1'b1),
        .clr     (1'b0),
        .div     (sys_div_w),
        .tick    (sys_tick)
    );

    // Compatibility encodings, or the free divider in improved mode
    wire logic [7:0] compat_div_w =
        (ctl.conv_clock_divider_select == 2'b00) ? DIV_SEL0 :
        (ctl.conv_clock_divider_select == 2'b01) ? DIV_SEL1 :
        (ctl.conv_clock_divider_select == 2'b10) ? DIV_SEL2 : DIV_SEL3;
    wire logic [7:0] bc_div_w = ctl.improved_clk ? inclk_q + 8'h01 : compat_div_w;

    // Basic clock counts system strobes, restarted at a start
    adcct_tick_div #(.W(8)) u_bc_div (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .step    (sys_tick),
        .clr     (start_w),
        .div     (bc_div_w),
        .tick    (bc_tick)
    );

    // Core, bus controller and peripherals share one rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_en_q <= 1'b0;
            sys_en_q <= 1'b0;
        end else if (clk_en) begin
            cpu_en_q <= sys_tick;
            sys_en_q <= sys_tick;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    wire logic [6:0] smp_len_w =
        (ctl.sample_time_select == 2'b00) ? SMP_SEL0 :
        (ctl.sample_time_select == 2'b01) ? SMP_SEL1 :
        (ctl.sample_time_select == 2'b10) ? SMP_SEL2 : SMP_SEL3;
    wire logic [6:0] conv_len_w = ctl.res8 ?
        (ctl.post_cal_en ? CONV8_PC : CONV8_NPC) :
        (ctl.post_cal_en ? CONV10_PC : CONV10_NPC);

    wire logic smp_end  = (state_q == ST_SAMPLE) & bc_tick & (cnt_q == smp_len_w - 7'h01);
    wire logic conv_end = (state_q == ST_CONV) & bc_tick & (cnt_q == conv_len_w - 7'h01);
    wire logic load_end = (state_q == ST_LOAD) & sys_tick & (cnt_q == LOAD_SYS - 7'h01);
    wire logic phase_step = (state_q == ST_LOAD) ? sys_tick : bc_tick;

    // Clamp outside the reference range
    wire logic [9:0] res_code_w = held_q.code & (ctl.res8 ? 10'h3FC : 10'h3FF);
    wire logic [9:0] clamp_w = held_q.below ? CODE_ZERO :
                               held_q.above ? CODE_FULL : res_code_w;

    // Next state: sample, determine, load
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:   if (start_w) state_d = ST_SAMPLE;
            ST_SAMPLE: if (smp_end) state_d = ST_CONV;
            ST_CONV:   if (conv_end) state_d = ST_LOAD;
            ST_LOAD:   if (load_end) state_d = ST_IDLE;
            default:   state_d = ST_IDLE;
        endcase
    end

    // Phase counter restarts on every state change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q   <= 7'h00;
        end else if (clk_en) begin
            state_q <= state_d;
            if (state_d != state_q) cnt_q <= 7'h00;
            else if (busy_w && phase_step) cnt_q <= cnt_q + 7'h01;
        end
    end

    // Input held at end of sampling; result and flag on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_q   <= '0;
            result_q <= CODE_ZERO;
            done_q   <= 1'b0;
            sample_q <= 1'b0;
        end else if (clk_en) begin
            sample_q <= (state_d == ST_SAMPLE);
            if (smp_end) held_q <= pin_s_q;
            if (load_end) result_q <= clamp_w;
            if (load_end) done_q <= 1'b1;
            else if (done_clr) done_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Reset calibration
    // ----------------------------------------------------------------
    // Count pauses while converting, so conversions stretch calibration
    wire logic cal_step = cal_q & bc_tick & ~busy_w;
    wire logic cal_end  = cal_step & (cal_cnt_q >= CAL_MIN_BC - 14'h0001) &
                          (~noisy_s_q | (cal_cnt_q >= CAL_MAX_BC - 14'h0001));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_q     <= 1'b1;
            cal_cnt_q <= 14'h0000;
        end else if (clk_en) begin
            if (cal_end) cal_q <= 1'b0;
            if (cal_step) cal_cnt_q <= cal_cnt_q + 14'h0001;
        end
    end

    // Outputs straight from flops
    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign cpu_clk_en = cpu_en_q;
    assign sys_clk_en = sys_en_q;
    assign sample_en  = sample_q;
    assign cal_busy   = cal_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_samp_to_conv;
        clk_en && smp_end;
    endsequence
    sequence s_conv_to_load;
        clk_en && conv_end;
    endsequence

    div_select_map_a: assert property (
        !ctl.improved_clk && ctl.conv_clock_divider_select == 2'b10 |-> bc_div_w == 8'h10)
        else $error("basic clock divider mismatch");
    sample_len_a: assert property (
        s_samp_to_conv |-> cnt_q == (7'h08 << ctl.sample_time_select) - 7'h01 && state_d == ST_CONV)
        else $error("sample phase length wrong");
    conv10_len_a: assert property (
        s_conv_to_load ##0 !ctl.res8 |-> cnt_q == (ctl.post_cal_en ? 7'h33 : 7'h27))
        else $error("10-bit conversion length wrong");
    conv8_len_a: assert property (
        s_conv_to_load ##0 ctl.res8 |-> cnt_q == (ctl.post_cal_en ? 7'h2B : 7'h1F))
        else $error("8-bit conversion length wrong");
    postcal_diff_a: assert property (
        ctl.post_cal_en |-> conv_len_w == (ctl.res8 ? CONV8_NPC : CONV10_NPC) + POSTCAL_BC)
        else $error("post-calibration difference wrong");
    phase_order_a: assert property (
        clk_en && state_q != state_d && state_d == ST_LOAD |-> state_q == ST_CONV)
        else $error("load not preceded by determination");
    clamp_below_a: assert property (
        clk_en && load_end && held_q.below |=> result_q == CODE_ZERO)
        else $error("result not clamped to zero");
    cal_min_a: assert property (
        clk_en && $fell(cal_q) |-> cal_cnt_q >= CAL_MIN_BC)
        else $error("calibration ended early");
    cal_pause_a: assert property (
        busy_w && cal_q && clk_en |=> $stable(cal_cnt_q))
        else $error("calibration counted during conversion");
    halve_tick_a: assert property (
        halve_q && $past(halve_q) && sys_tick && clk_en ##1 halve_q |-> !sys_tick)
        else $error("halved system strobe too fast");
    done_load_a: assert property (
        clk_en && load_end |=> done_q && result_q == $past(clamp_w) && state_q == ST_IDLE)
        else $error("done flag not set with result load");

endmodule

`default_nettype wire

/* File: tb/adcct_tb.sv */
// Purpose: Self-checking bench for the converter timing block over APB
// Assumes: One wait state per APB access; sample_en aligned with the phase
// Notes:   Phase lengths are measured at the pins, conversion end by polling

`timescale 1ns/10ps
`default_nettype none

module tb import adcct_pkg::*;;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic              pclk;
    logic              presetn;
    logic              clk_en;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic [9:0]        ain_code;
    logic              ain_below;
    logic              ain_above;
    logic              ref_noisy;
    logic              cpu_clk_en;
    logic              sys_clk_en;
    logic              sample_en;
    logic              cal_busy;
    logic [31:0]       rdata;
    logic              rerr;
    int                fail_count;
    int                cmp_count;
    int                since_rst;
    int                n;

    // Conversion table: control word, system period, divider, sample, body
    logic [15:0] t_ctrl [9] = '{16'h4005, 16'h4001, 16'h4007, 16'h4003, 16'h1005,
                                16'hA005, 16'hF005, 16'h0805, 16'h4005};
    // Rows 5 and 6 hold the basic clock at 12.5 MHz; others trade that for run time
    int          t_p [9]    = '{1, 1, 1, 1, 1, 1, 2, 1, 2};
    int          t_d [9]    = '{2, 2, 2, 2, 4, 16, 8, 3, 2};
    int          t_s [9]    = '{8, 8, 8, 8, 16, 32, 64, 8, 8};
    int          t_c [9]    = '{52, 40, 44, 32, 52, 52, 52, 52, 52};
    logic [11:0] t_ain [9]  = '{12'h2A5, 12'hAA5, 12'h2A7, 12'h555, 12'hC10,
                                12'h001, 12'h3FE, 12'h123, 12'h2A5};
    logic [9:0]  t_res [9]  = '{10'h2A5, 10'h000, 10'h2A4, 10'h3FF, 10'h000,
                                10'h001, 10'h3FE, 10'h123, 10'h2A5};

    adcct_timing dut (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .ain_code   (ain_code),
        .ain_below  (ain_below),
        .ain_above  (ain_above),
        .ref_noisy  (ref_noisy),
        .cpu_clk_en (cpu_clk_en),
        .sys_clk_en (sys_clk_en),
        .sample_en  (sample_en),
        .cal_busy   (cal_busy)
    );

    // ----------------------------------------------------------------
    // Clock and cycle count since reset release
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) since_rst <= 0;
        else since_rst <= since_rst + 1;
    end

    // ----------------------------------------------------------------
    // Compare, report and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Counts are bench integers, so a window is compared, not a value
    task automatic rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("mismatch at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic close_out;
        if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Setup, access until pready, then release; only the watchdog bounds the wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    task automatic wait_until(input int c);
        while (since_rst < c) @(posedge pclk);
    endtask

    task automatic do_reset(input logic noisy);
        presetn   <= 1'b0;
        ref_noisy <= noisy;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // One conversion: sample length at the pin, body length by polling busy
    task automatic conv(input int i);
        int t0;
        int k;
        k = 0;
        {ain_below, ain_above, ain_code} <= t_ain[i];
        apb(1'b1, OFS_SYSCTL, {31'h0, t_p[i] == 2});
        apb(1'b1, OFS_CTRL, {16'h0, t_ctrl[i]});
        while (sample_en !== 1'b1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        k = 0;
        while (sample_en === 1'b1 && k < 5000) begin
            @(posedge pclk);
            k++;
        end
        rng(k, t_p[i] * t_d[i] * t_s[i], t_p[i] * t_d[i] * t_s[i] + 1);
        t0 = since_rst;
        k  = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            k++;
        end while (rdata[ST_BUSY_BIT] !== 1'b0 && k < 2000);
        rng(since_rst - t0, t_p[i] * (t_d[i] * t_c[i] + 6), t_p[i] * (t_d[i] * t_c[i] + 6) + 10);
        chk({31'h0, rdata[ST_DONE_BIT]}, 32'h1);
        rdc(OFS_RESULT, {22'h0, t_res[i]});
        apb(1'b1, OFS_STATUS, 32'h2);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({31'h0, rdata[ST_DONE_BIT]}, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Watchdog: whole run is about 30000 cycles
    // ----------------------------------------------------------------
    initial begin
        #400000;
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        fail_count = 0;
        cmp_count  = 0;
        presetn    = 1'b0;
        clk_en     = 1'b1;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = '0;
        pwdata     = '0;
        ain_code   = 10'h000;
        ain_below  = 1'b0;
        ain_above  = 1'b0;
        ref_noisy  = 1'b0;
        do_reset(1'b0);
        // Reset values, then an unmapped place; no conversion disturbs calibration
        rdc(OFS_CTRL, 32'h0000_0004);
        rdc(OFS_STATUS, 32'h0000_0004);
        rdc(OFS_RESULT, 32'h0);
        rdc(OFS_SYSCTL, 32'h0);
        rdc(OFS_INCLK, 32'h0000_0003);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        chk({31'h0, rerr}, 32'h1);
        rdc(12'h014, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        // Quiet reference: calibration ends just past its minimum length
        wait_until(484 * 4 - 30);
        chk({31'h0, cal_busy}, 32'h1);
        wait_until(484 * 4 + 40);
        chk({31'h0, cal_busy}, 32'h0);
        // Read-write fields
        apb(1'b1, OFS_CTRL, 32'h0000_F806);
        rdc(OFS_CTRL, 32'h0000_F806);
        apb(1'b1, OFS_INCLK, 32'h0000_0002);
        rdc(OFS_INCLK, 32'h0000_0002);
        // CPU and system strobes, full rate then halved
        for (int h = 0; h < 2; h++) begin
            apb(1'b1, OFS_SYSCTL, {31'h0, h == 1});
            repeat (2) @(posedge pclk);
            n = 0;
            repeat (16) begin
                @(posedge pclk);
                n += (cpu_clk_en === 1'b1);
                chk({31'h0, sys_clk_en}, {31'h0, cpu_clk_en});
            end
            rng(n, 16 >> h, 16 >> h);
        end
        // Enable low must freeze the halved strobe where it stands
        clk_en <= 1'b0;
        @(posedge pclk);
        n = {31'h0, cpu_clk_en};
        repeat (8) begin
            @(posedge pclk);
            chk({31'h0, cpu_clk_en}, n);
        end
        clk_en <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            conv(i);
        end
        // Noisy reference: full calibration, lengthened by one conversion
        do_reset(1'b1);
        conv(0);
        wait_until(11696 * 2 + 60);
        chk({31'h0, cal_busy}, 32'h1);
        wait_until(11696 * 2 + 300);
        chk({31'h0, cal_busy}, 32'h0);
        close_out();
    end

endmodule

`default_nettype wire
